//--- rtl/gpld_defs.vh
// Purpose: Offsets, field positions and reset values of the global protect
//          and lock decoder.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef GPLD_DEFS_VH
`define GPLD_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define GPLD_OFS_STATUS   8'h00
`define GPLD_OFS_SECTORS  8'h04
`define GPLD_OFS_WRSTAT   8'h08
`define GPLD_OFS_RESULT   8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define GPLD_LOCK_BIT     7
`define GPLD_GLOB_HI      5
`define GPLD_GLOB_LO      2
`define GPLD_ABORT_BIT    8
`define GPLD_STAT_WP_BIT  4

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define GPLD_LOCK_RST     1'b0
`define GPLD_FLAG_RST     1'b1
`define GPLD_GLOB_ZERO    4'h0
`define GPLD_GLOB_ONES    4'hF
`define GPLD_SUM_NONE     2'b00
`define GPLD_SUM_SOME     2'b01
`define GPLD_SUM_ALL      2'b11

`endif

//--- rtl/gpld_sector_flag.v
// Purpose: One sector protection flag with global set and clear.
// Assumes: Set and clear are never both high in one cycle.
// Notes:   Comes out of reset protected.
`timescale 1ns/1ns
`default_nettype none
`include "gpld_defs.vh"

module gpld_sector_flag (
  // Clock and reset
  input  wire clk_sys_i,
  input  wire reset_i,
  // Global operations
  input  wire glob_set_i,
  input  wire glob_clr_i,
  // Flag
  output wire flag_o
);

  reg flag_ff;
  reg nxt_flag;

  always @* begin
    nxt_flag = flag_ff;
    if (glob_clr_i) begin
      nxt_flag = 1'b0;
    end else if (glob_set_i) begin
      nxt_flag = 1'b1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      flag_ff <= `GPLD_FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag_o = flag_ff;

endmodule

`default_nettype wire

//--- rtl/gpld_top.v
// Purpose: Decodes status byte writes into global protect and unprotect of
//          all sector flags and updates the protection lock bit.
// Assumes: AHB-Lite single word transfers; write-protect pin is async.
// Notes:   A write to the status-write register is one complete status
//          write command; bit 8 set marks it as aborted framing.
`timescale 1ns/1ns
`default_nettype none
`include "gpld_defs.vh"

module gpld_top #(
  parameter NUM_SECTORS = 4
) (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        reset_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  // Write-protect pin, active low
  input  wire        wp_n_i,
  // Protection state
  output wire [NUM_SECTORS-1:0] sector_prot_o,
  output wire        protection_lock_bit_o
);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  reg wp_meta_ff;
  reg wp_sync_ff;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      wp_meta_ff <= 1'b1;
      wp_sync_ff <= 1'b1;
    end else begin
      wp_meta_ff <= wp_n_i;
      wp_sync_ff <= wp_meta_ff;
    end
  end

  // ****************************************************************
  // AHB-Lite address and data phase
  // ****************************************************************
  reg        wr_pend_ff;
  reg  [7:0] wr_addr_ff;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;

  wire       addr_ok = hsel_i & htrans_i[1] & hready_i;
  wire [7:0] addr_lo = haddr_i[7:0];

  reg                   lock_ff;
  reg  [2:0]            result_ff;
  wire [NUM_SECTORS-1:0] flags;
  reg  [1:0]            summary;

  // Protection summary shown in place of the written glob bits
  always @* begin
    if (&flags) begin
      summary = `GPLD_SUM_ALL;
    end else if (|flags) begin
      summary = `GPLD_SUM_SOME;
    end else begin
      summary = `GPLD_SUM_NONE;
    end
  end

  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (addr_lo)
      `GPLD_OFS_STATUS: begin
        nxt_rdata[`GPLD_LOCK_BIT]    = lock_ff;
        nxt_rdata[`GPLD_STAT_WP_BIT] = ~wp_sync_ff;
        nxt_rdata[3:2]               = summary;
      end
      `GPLD_OFS_SECTORS: begin
        nxt_rdata[NUM_SECTORS-1:0] = flags;
      end
      `GPLD_OFS_RESULT: begin
        nxt_rdata[2:0] = result_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered at the address phase so it stands in the data phase
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= addr_ok & hwrite_i;
      if (addr_ok) begin
        wr_addr_ff <= addr_lo;
        rdata_ff   <= hwrite_i ? 32'h0000_0000 : nxt_rdata;
      end
    end
  end

  assign hrdata_o    = rdata_ff;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // ****************************************************************
  // Status write decode
  // ****************************************************************
  wire       cmd_write = wr_pend_ff & (wr_addr_ff == `GPLD_OFS_WRSTAT);
  wire       cmd_abort = hwdata_i[`GPLD_ABORT_BIT];
  wire       cmd_exec  = cmd_write & ~cmd_abort;
  wire [3:0] glob_bits = hwdata_i[`GPLD_GLOB_HI:`GPLD_GLOB_LO];
  wire       new_lock  = hwdata_i[`GPLD_LOCK_BIT];
  // Low pin with lock set is the hard lock: neither the lock nor the flags may change
  wire       hard_lock = lock_ff & ~wp_sync_ff;
  wire       may_glob  = cmd_exec & ~lock_ff;
  wire       glob_clr  = may_glob & (glob_bits == `GPLD_GLOB_ZERO);
  wire       glob_set  = may_glob & (glob_bits == `GPLD_GLOB_ONES);
  // Other patterns drive neither strobe and flags hold
  wire       lock_wr   = cmd_exec & ~hard_lock;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      lock_ff   <= `GPLD_LOCK_RST;
      result_ff <= 3'b000;
    end else begin
      if (lock_wr) begin
        lock_ff <= new_lock;
      end
      if (cmd_write) begin
        // Last outcome: [0] unprotect, [1] protect, [2] aborted
        result_ff <= {cmd_abort, glob_set, glob_clr};
      end
    end
  end

  // ****************************************************************
  // Sector flags
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SECTORS; gi = gi + 1) begin : g_sec
      gpld_sector_flag u_flag (
        .clk_sys_i  (clk_sys_i),
        .reset_i    (reset_i),
        .glob_set_i (glob_set),
        .glob_clr_i (glob_clr),
        .flag_o     (flags[gi])
      );
    end
  endgenerate

  assign sector_prot_o         = flags;
  assign protection_lock_bit_o = lock_ff;

endmodule

`default_nettype wire

//--- tb/gpld_props.sv
// Purpose: port assertions. Assumes: one clock. Notes: pin sync mirrored
`timescale 1ns/1ns
`default_nettype none
module gpld_props #(parameter NUM_SECTORS = 4) (
  input wire logic clk_sys_i, reset_i, hsel_i, hwrite_i, hready_i, wp_n_i,
  input wire logic protection_lock_bit_o,
  input wire logic [1:0] htrans_i,
  input wire logic [31:0] haddr_i, hwdata_i,
  input wire logic [NUM_SECTORS-1:0] sector_prot_o
);
  logic wr_q, p1, p2;
  // Mirror of the two-flop pin synchroniser, which resets to pin high
  always @(posedge clk_sys_i) begin
    wr_q <= !reset_i && hsel_i && htrans_i[1] && hready_i && hwrite_i
            && haddr_i[7:0] == 8'h08;
    p1 <= reset_i | wp_n_i;
    p2 <= reset_i | p1;
  end
  wire logic lk = protection_lock_bit_o;
  wire logic ok = wr_q && !hwdata_i[8];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence glob_wr(logic [3:0] c);
    ok && !lk && hwdata_i[5:2] == c;
  endsequence
  chk_glob_clear: assert property (glob_wr(4'h0) |=> sector_prot_o == 0)
    else $error("global clear missed");
  chk_glob_set: assert property (glob_wr(4'hF) |=> &sector_prot_o)
    else $error("global set missed");
  chk_other_code: assert property (ok && hwdata_i[5:2] != 4'h0
    && hwdata_i[5:2] != 4'hF |=> $stable(sector_prot_o)) else $error("flags moved");
  chk_locked_flags: assert property (ok && lk |=> $stable(sector_prot_o))
    else $error("flags moved while locked");
  chk_hard_lock: assert property (ok && lk && !p2 |=> lk)
    else $error("lock left while pin low");
  chk_lock_store: assert property (ok && (!lk || p2) |=> lk == $past(hwdata_i[7]))
    else $error("lock not stored");
  chk_abort_none: assert property (wr_q && hwdata_i[8] |=> $stable({lk, sector_prot_o}))
    else $error("aborted write acted");
  chk_idle_hold: assert property (!wr_q |=> $stable({lk, sector_prot_o}))
    else $error("state moved without write");
endmodule
`default_nettype wire

//--- tb/gpld_host.sv
// Purpose: AHB-Lite host of status writes. Assumes: one slave. Notes: owns pin
`timescale 1ns/1ns
`default_nettype none
module gpld_host (
  input  wire logic        clk_sys_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output var  logic        hsel_o = 1'b0,
  output var  logic [31:0] haddr_o = 32'h0,
  output var  logic [1:0]  htrans_o = 2'h0,
  output var  logic        hwrite_o = 1'b0,
  output var  logic [2:0]  hsize_o = 3'h0,
  output var  logic [31:0] hwdata_o = 32'h0,
  output var  logic        wp_n_o = 1'b1
);
  task automatic hold;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hready_i !== 1'b1 && n < 16);
    if (hready_i !== 1'b1) gpld_top_tb.report_and_stop(1'b1);
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      output logic [31:0] q);
    hsel_o <= 1'b1;
    haddr_o <= a;
    hwrite_o <= w;
    hsize_o <= 3'h2;
    htrans_o <= 2'h2;
    hold();
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= d;
    hold();
    q = hrdata_i;
  endtask
  // Pin settles through the synchroniser before the next write
  task automatic pin(input logic v);
    wp_n_o <= v;
    repeat (3) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

//--- tb/gpld_top_tb.sv
// Purpose: decoder bench. Assumes: zero wait slave. Notes: NUM_SECTORS 4
`timescale 1ns/1ns
`default_nettype none
module gpld_top_tb;
  logic clk_sys_i = 0;
  logic reset_i = 1;
  logic hready, hresp, lock, hwrite, wp_n, hsel;
  logic [2:0] hsize;
  logic [1:0] htrans;
  logic [3:0] flags;
  logic [31:0] haddr, hwdata, hrdata, q;
  int failures = 0;
  int checks = 0;
  initial forever #4 clk_sys_i = ~clk_sys_i;
  gpld_top #(.NUM_SECTORS(4)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .wp_n_i(wp_n),
    .sector_prot_o(flags), .protection_lock_bit_o(lock));
  gpld_host host (.clk_sys_i(clk_sys_i), .hready_i(hready),
    .hrdata_i(hrdata), .hsel_o(hsel), .hsize_o(hsize),
    .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hwdata_o(hwdata), .wp_n_o(wp_n));
  task automatic chk(input string nm, input logic [31:0] exp, seen);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wst(input logic [31:0] d, input logic [4:0] exp);
    host.xfer(1'b1, 32'h0000_0008, d, q);
    // Outputs moved at the data-phase edge; look one edge later
    @(posedge clk_sys_i);
    chk("lock_flags", {27'h0, exp}, {27'h0, lock, flags});
    chk("write_rdata", 32'h0000_0000, q);
    $display("write %h done", d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, {24'h0, a}, 32'h0, q);
    chk("read_data", exp, q);
    chk("read_resp", 32'h0000_0000, {31'h0, hresp});
    $display("read %h done", a);
  endtask
  task automatic report_and_stop(input bit hung);
    if (hung) failures++;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    report_and_stop(1'b1);
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("reset", 32'h0000_000F, {27'h0, lock, flags});
    wst(32'h0000_0004, 5'h0F);
    wst(32'h0000_0000, 5'h00);
    wst(32'h0000_0038, 5'h00);
    wst(32'h0000_003C, 5'h0F);
    rd(8'h04, 32'h0000_000F);
    rd(8'h0C, 32'h0000_0002);
    wst(32'h0000_0100, 5'h0F);
    rd(8'h0C, 32'h0000_0004);
    rd(8'h00, 32'h0000_000C);
    wst(32'h0000_0080, 5'h10);
    host.pin(1'b0);
    wst(32'h0000_003C, 5'h10);
    rd(8'h00, 32'h0000_0090);
    host.pin(1'b1);
    wst(32'h0000_003C, 5'h00);
    wst(32'h0000_00BC, 5'h1F);
    wst(32'h0000_0080, 5'h1F);
    // Reset in mid-run drops the lock and protects every sector again
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("rerun_reset", 32'h0000_000F, {27'h0, lock, flags});
    $display("mid-run reset done");
    report_and_stop(1'b0);
  end
endmodule
bind gpld_top gpld_props #(.NUM_SECTORS(NUM_SECTORS)) props (.*);
`default_nettype wire
